// ### hdl/axis_status_record_packer.sv
// Notes on behaviour
// - Block opens: status word, switches, stop code
// - Then reference position, then motor position
// - Then position error, auxiliary position, velocity
// - Ends torque, analog, hall, reserved, user variable
// - Blocks repeat D to H, ending byte 369
// - Thread byte bit n is thread n running
// - Plane word bits 15, 5, 4, 3 used
// - Axis status upper byte motion mode flags
// - Axis status lower byte motion phase flags
// - Switch byte: latch, limits, home, stepper
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module axis_status_record_packer #(
   parameter int NUM_AXES = record_pkg::NUM_AXES,
   parameter int FIFO_DEPTH = record_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic [record_pkg::ADDR_W-1:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rd_data,
   input wire record_pkg::axis_in_t [NUM_AXES-1:0] axis_in,
   input wire logic [record_pkg::THREAD_COUNT-1:0] thread_running,
   input wire record_pkg::plane_status_t plane_status,
   output logic rec_valid,
   output record_pkg::rec_byte_t rec_out,
   input wire logic rec_ready
);
   localparam int BB = record_pkg::BLOCK_BYTES;
   localparam int AXW = $clog2(NUM_AXES + 1);
   localparam logic [AXW-1:0] LAST_AXIS = AXW'(NUM_AXES - 1);
   localparam logic [5:0] LAST_BYTE = 6'(BB - 1);

   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_LOAD = 3'b010,
      S_SEND = 3'b100
   } seq_state_t;

   // Latch, limit and home levels arrive from pins: two flops each
   logic [3:0] lvl_meta_r [NUM_AXES];
   logic [3:0] lvl_sync_r [NUM_AXES];
   genvar g;
   generate
      for (g = 0; g < NUM_AXES; g++) begin : g_sync
         always_ff @(posedge clk) begin
            if (srst) begin
               lvl_meta_r[g] <= 4'h0;
               lvl_sync_r[g] <= 4'h0;
            end else if (ce) begin
               lvl_meta_r[g] <= {axis_in[g].switches.latch_level,
                                 axis_in[g].switches.forward_limit,
                                 axis_in[g].switches.reverse_limit,
                                 axis_in[g].switches.home_level};
               lvl_sync_r[g] <= lvl_meta_r[g];
            end
         end
      end
   endgenerate

   // Lay one axis block out as bytes, byte 0 in the low bits
   function automatic logic [8*BB-1:0] build_block(input record_pkg::axis_in_t a,
                                                    input logic [3:0] lv);
      logic [8*BB-1:0] b;
      record_pkg::axis_switch_t sw;
      b = '0;
      sw = a.switches;
      sw.latch_level = lv[3];
      sw.forward_limit = lv[2];
      sw.reverse_limit = lv[1];
      sw.home_level = lv[0];
      sw.unused = 2'h0;
      // Status flags keep their bit places
      b[record_pkg::OFF_STATUS*8 +: 16] = a.status;
      // Switches and stop code follow the status word
      b[record_pkg::OFF_SWITCH*8 +: 8] = sw;
      b[record_pkg::OFF_STOP*8 +: 8] = a.stop_code;
      b[record_pkg::OFF_REF*8 +: 32] = a.ref_pos;
      b[record_pkg::OFF_MOTOR*8 +: 32] = a.motor_pos;
      b[record_pkg::OFF_ERR*8 +: 32] = a.pos_err;
      b[record_pkg::OFF_AUX*8 +: 32] = a.aux_pos;
      b[record_pkg::OFF_VEL*8 +: 32] = a.velocity;
      // Tail fields; the reserved byte keeps its zero
      b[record_pkg::OFF_TORQUE*8 +: 32] = a.torque;
      b[record_pkg::OFF_ANALOG*8 +: 16] = a.analog;
      b[record_pkg::OFF_HALL*8 +: 8] = a.hall;
      b[record_pkg::OFF_USER*8 +: 32] = a.user_status_variable;
      return b;
   endfunction

   seq_state_t state_r, state_nxt;
   logic [AXW-1:0] axis_r, axis_nxt;
   logic [5:0] byte_r, byte_nxt;
   logic [8:0] off_r, off_nxt;
   logic [8*BB-1:0] blk_r, blk_nxt;
   logic [7:0] rec_cnt_r, rec_cnt_nxt;
   logic auto_r, auto_nxt, go_r, go_nxt;
   logic [31:0] rd_data_r, rd_data_nxt;
   record_pkg::rec_byte_t push_data;
   logic push_valid, push_ready, accept;
   record_pkg::axis_in_t cur_in;
   logic [3:0] cur_lvl;

   assign cur_in = axis_in[axis_r];
   assign cur_lvl = lvl_sync_r[axis_r];
   assign push_valid = (state_r == S_SEND);
   assign accept = push_valid && push_ready;
   // Bytes leave low first, so multi-byte fields are LSB first
   assign push_data.data = blk_r[byte_r*8 +: 8];
   assign push_data.offset = off_r;
   assign push_data.last = (off_r == record_pkg::REC_LAST_BYTE);

   // Sequencer: snapshot one axis, then stream its bytes
   always_comb begin
      state_nxt = state_r;
      axis_nxt = axis_r;
      byte_nxt = byte_r;
      off_nxt = off_r;
      blk_nxt = blk_r;
      rec_cnt_nxt = rec_cnt_r;
      unique case (state_r)
         S_IDLE: begin
            if (go_r || auto_r) begin
               state_nxt = S_LOAD;
               axis_nxt = '0;
               off_nxt = record_pkg::REC_FIRST_BYTE;
            end
         end
         S_LOAD: begin
            // Per-axis snapshot keeps each block coherent without a full copy
            blk_nxt = build_block(cur_in, cur_lvl);
            byte_nxt = '0;
            state_nxt = S_SEND;
         end
         S_SEND: begin
            if (accept) begin
               off_nxt = off_r + 9'h001;
               byte_nxt = byte_r + 6'h01;
               if (byte_r == LAST_BYTE) begin
                  if (axis_r == LAST_AXIS) begin
                     state_nxt = S_IDLE;
                     rec_cnt_nxt = rec_cnt_r + 8'h01;
                  end else begin
                     state_nxt = S_LOAD;
                     axis_nxt = axis_r + 1'b1;
                  end
               end
            end
         end
         default: begin
            state_nxt = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_r <= S_IDLE;
         axis_r <= '0;
         byte_r <= 6'h00;
         off_r <= record_pkg::REC_FIRST_BYTE;
         blk_r <= '0;
         rec_cnt_r <= 8'h00;
      end else if (ce) begin
         state_r <= state_nxt;
         axis_r <= axis_nxt;
         byte_r <= byte_nxt;
         off_r <= off_nxt;
         blk_r <= blk_nxt;
         rec_cnt_r <= rec_cnt_nxt;
      end
   end

   // Register port: control writes, one-cycle-late read data
   always_comb begin
      auto_nxt = auto_r;
      go_nxt = 1'b0;
      rd_data_nxt = 32'h0000_0000;
      if (wr_en && addr == record_pkg::REG_CTRL) begin
         auto_nxt = wr_data[record_pkg::CTRL_AUTO_BIT];
         go_nxt = wr_data[record_pkg::CTRL_GO_BIT];
      end
      if (rd_en) begin
         unique case (addr)
            record_pkg::REG_CTRL: begin
               rd_data_nxt[record_pkg::CTRL_AUTO_BIT] = auto_r;
            end
            record_pkg::REG_STATUS: begin
               rd_data_nxt[record_pkg::STATUS_BUSY_BIT] = (state_r != S_IDLE);
               rd_data_nxt[record_pkg::STATUS_FULL_BIT] = !push_ready;
               rd_data_nxt[record_pkg::STATUS_CNT_LSB +: 8] = rec_cnt_r;
            end
            record_pkg::REG_THREAD: begin
               rd_data_nxt[record_pkg::THREAD_COUNT-1:0] = thread_running;
            end
            record_pkg::REG_PLANE: begin
               rd_data_nxt[record_pkg::PLANE_MOVE_BIT] = plane_status.move_in_progress;
               rd_data_nxt[record_pkg::PLANE_SLEW_BIT] = plane_status.slewing;
               rd_data_nxt[record_pkg::PLANE_STOP_BIT] = plane_status.stopping;
               rd_data_nxt[record_pkg::PLANE_DECEL_BIT] = plane_status.final_decel;
            end
            default: begin
               rd_data_nxt = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         auto_r <= record_pkg::CTRL_AUTO_RESET;
         go_r <= 1'b0;
         rd_data_r <= 32'h0000_0000;
      end else if (ce) begin
         auto_r <= auto_nxt;
         go_r <= go_nxt;
         rd_data_r <= rd_data_nxt;
      end
   end

   assign rd_data = rd_data_r;

   // Output buffer; a stalled reader holds the sequencer in S_SEND
   fifo_buf #(
      .WIDTH($bits(record_pkg::rec_byte_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .in_valid(push_valid),
      .in_data(push_data),
      .in_ready(push_ready),
      .out_valid(rec_valid),
      .out_data(rec_out),
      .out_ready(rec_ready)
   );

   // Checks on the record layout and the register port
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   sequence load_s;
      state_r == S_LOAD && ce;
   endsequence

   sequence start_s;
      state_r == S_IDLE && ce && (go_r || auto_r);
   endsequence

   status_word_a: assert property (load_s |=>
      blk_r[15:0] == $past(cur_in.status) && blk_r[31:24] == $past(cur_in.stop_code))
      else $error("status word or stop code misplaced");

   positions_a: assert property (load_s |=>
      blk_r[63:32] == $past(cur_in.ref_pos) && blk_r[95:64] == $past(cur_in.motor_pos))
      else $error("reference or motor position misplaced");

   error_aux_vel_a: assert property (load_s |=>
      blk_r[127:96] == $past(cur_in.pos_err) && blk_r[159:128] == $past(cur_in.aux_pos)
      && blk_r[191:160] == $past(cur_in.velocity))
      else $error("error, auxiliary or velocity misplaced");

   block_tail_a: assert property (load_s |=>
      blk_r[223:192] == $past(cur_in.torque) && blk_r[239:224] == $past(cur_in.analog)
      && blk_r[247:240] == $past(cur_in.hall) && blk_r[287:256] ==
      $past(cur_in.user_status_variable))
      else $error("block tail misplaced");

   record_span_a: assert property (start_s ##1 load_s |=>
      off_r == record_pkg::REC_FIRST_BYTE && byte_r == 6'h00)
      else $error("record does not open at the first axis byte");

   last_byte_a: assert property (accept && push_data.last |->
      axis_r == LAST_AXIS && byte_r == LAST_BYTE
      && off_r == record_pkg::AXIS_H_FIRST_BYTE + 9'(BB - 1))
      else $error("record end misplaced");

   lsb_first_a: assert property (load_s ##1 (accept && byte_r == 6'h00) |->
      push_data.data == blk_r[7:0] && blk_r[255:248] == 8'h00)
      else $error("byte order or reserved byte wrong");

   thread_read_a: assert property (rd_en && ce && addr == record_pkg::REG_THREAD |=>
      rd_data == {24'h000000, $past(thread_running)})
      else $error("thread byte wrong");

   plane_read_a: assert property (rd_en && ce && addr == record_pkg::REG_PLANE |=>
      rd_data[15] == $past(plane_status.move_in_progress) && rd_data[5:3] ==
      {$past(plane_status.slewing), $past(plane_status.stopping),
      $past(plane_status.final_decel)} && rd_data[14:6] == 9'h000)
      else $error("plane word wrong");

   status_upper_a: assert property (load_s |=>
      blk_r[15] == $past(cur_in.status.move_in_progress)
      && blk_r[8] == $past(cur_in.status.coord_mode))
      else $error("status upper byte wrong");

   status_lower_a: assert property (load_s |=>
      blk_r[7] == $past(cur_in.status.negative_dir)
      && blk_r[0] == $past(cur_in.status.motor_off))
      else $error("status lower byte wrong");

   switch_byte_a: assert property (load_s |=>
      blk_r[21:20] == 2'h0 && blk_r[23] == $past(cur_in.switches.latch_occurred)
      && blk_r[19] == $past(cur_lvl[2]) && blk_r[16] == $past(cur_in.switches.stepper_mode))
      else $error("switch byte wrong");

endmodule

`default_nettype wire

// ### hdl/fifo_buf.sv
`timescale 1ns/1ns
`default_nettype none

module fifo_buf #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic ov_r, ov_nxt;
   logic [WIDTH-1:0] od_r, od_nxt;
   logic push, pop;

   // Ready is honest: it falls only when every slot holds a word
   assign in_ready = (cnt_r != FULL_CNT);
   assign out_valid = ov_r;
   assign out_data = od_r;
   assign push = in_valid && in_ready;
   assign pop = (cnt_r != '0) && (!ov_r || out_ready);

   // Pointers, count and the registered read stage
   always_comb begin
      wp_nxt = push ? wp_r + 1'b1 : wp_r;
      rp_nxt = pop ? rp_r + 1'b1 : rp_r;
      cnt_nxt = cnt_r + CW'(push) - CW'(pop);
      ov_nxt = pop ? 1'b1 : (out_ready ? 1'b0 : ov_r);
      od_nxt = pop ? mem[rp_r] : od_r;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         ov_r <= 1'b0;
         od_r <= '0;
      end else if (ce) begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
         ov_r <= ov_nxt;
         od_r <= od_nxt;
      end
   end

   // Storage carries no reset, so it maps onto plain RAM
   always_ff @(posedge clk) begin
      if (ce && push) begin
         mem[wp_r] <= in_data;
      end
   end

endmodule

`default_nettype wire

// ### hdl/record_pkg.sv
package record_pkg;

   // Record geometry: five axis blocks, D through H
   localparam int NUM_AXES = 5;
   localparam int BLOCK_BYTES = 36;
   localparam int REC_OFFSET_W = 9;
   localparam logic [8:0] REC_FIRST_BYTE = 9'd190;
   localparam logic [8:0] REC_LAST_BYTE = 9'd369;
   localparam logic [8:0] AXIS_H_FIRST_BYTE = 9'd334;

   // Byte positions inside one axis block
   localparam int OFF_STATUS = 0;
   localparam int OFF_SWITCH = 2;
   localparam int OFF_STOP = 3;
   localparam int OFF_REF = 4;
   localparam int OFF_MOTOR = 8;
   localparam int OFF_ERR = 12;
   localparam int OFF_AUX = 16;
   localparam int OFF_VEL = 20;
   localparam int OFF_TORQUE = 24;
   localparam int OFF_ANALOG = 28;
   localparam int OFF_HALL = 30;
   localparam int OFF_RSVD = 31;
   localparam int OFF_USER = 32;

   // Register map of the software port
   localparam int ADDR_W = 4;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_THREAD = 4'h8;
   localparam logic [3:0] REG_PLANE = 4'hc;
   localparam int CTRL_AUTO_BIT = 0;
   localparam int CTRL_GO_BIT = 1;
   localparam logic CTRL_AUTO_RESET = 1'h0;
   localparam int STATUS_BUSY_BIT = 0;
   localparam int STATUS_FULL_BIT = 1;
   localparam int STATUS_CNT_LSB = 8;

   // Thread activity and coordinated-plane word layout
   localparam int THREAD_COUNT = 8;
   localparam int PLANE_MOVE_BIT = 15;
   localparam int PLANE_SLEW_BIT = 5;
   localparam int PLANE_STOP_BIT = 4;
   localparam int PLANE_DECEL_BIT = 3;

   // FIFO sizing
   localparam int FIFO_DEPTH = 16;

   typedef struct packed {
      logic move_in_progress;       // bit 15
      logic pos_mode_abs_or_rel;
      logic pos_mode_abs_only;
      logic edge_search_active;
      logic homing_active;
      logic homing_phase1_done;
      logic homing_phase2_or_index;
      logic coord_mode;             // bit 8
      logic negative_dir;           // bit 7
      logic contour_mode;
      logic slewing;
      logic stopping;
      logic final_decel;
      logic latch_armed;
      logic homing_phase3;
      logic motor_off;              // bit 0
   } axis_status_t;

   typedef struct packed {
      logic latch_occurred;         // bit 7
      logic latch_level;
      logic [1:0] unused;
      logic forward_limit;
      logic reverse_limit;
      logic home_level;
      logic stepper_mode;           // bit 0
   } axis_switch_t;

   typedef struct packed {
      logic move_in_progress;
      logic slewing;
      logic stopping;
      logic final_decel;
   } plane_status_t;

   typedef struct packed {
      axis_status_t status;
      axis_switch_t switches;
      logic [7:0] stop_code;
      logic signed [31:0] ref_pos;
      logic signed [31:0] motor_pos;
      logic signed [31:0] pos_err;
      logic signed [31:0] aux_pos;
      logic signed [31:0] velocity;
      logic signed [31:0] torque;
      logic signed [15:0] analog;
      logic [7:0] hall;
      logic signed [31:0] user_status_variable;
   } axis_in_t;

   typedef struct packed {
      logic last;
      logic [8:0] offset;
      logic [7:0] data;
   } rec_byte_t;

endpackage

// ### sim/host_reader.sv
`timescale 1ns/1ns
`default_nettype none

module host_reader (
   input wire logic clk,
   input wire logic srst,
   input wire logic stall,
   input wire logic rec_valid,
   input wire record_pkg::rec_byte_t rec_out,
   output logic rec_ready
);
   logic [7:0] mem [190:369];
   logic last_seen [190:369];
   int count;
   int order_errs;
   logic [8:0] prev_r;
   logic [2:0] pace_r;

   // Host refuses three beats in eight so the packer must hold its byte
   always @(posedge clk) begin
      if (srst) begin
         rec_ready <= 1'b0;
         pace_r <= 3'h0;
         prev_r <= 9'h0;
         count <= 0;
         order_errs <= 0;
      end else begin
         pace_r <= pace_r + 3'h1;
         rec_ready <= !stall && (pace_r < 3'h5);
         if (rec_valid && rec_ready) begin
            count <= count + 1;
            if (rec_out.offset <= prev_r || rec_out.offset < 9'h0be
                || rec_out.offset > 9'h171) begin
               order_errs <= order_errs + 1;
            end else begin
               mem[rec_out.offset] <= rec_out.data;
               last_seen[rec_out.offset] <= rec_out.last;
            end
            prev_r <= rec_out.last ? 9'h0 : rec_out.offset;
         end
      end
   end
endmodule

`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
   logic clk;
   logic srst;
   logic ce;
   logic [record_pkg::ADDR_W-1:0] addr;
   logic [31:0] wr_data;
   logic wr_en;
   logic rd_en;
   logic [31:0] rd_data;
   record_pkg::axis_in_t [record_pkg::NUM_AXES-1:0] axis_in;
   logic [record_pkg::THREAD_COUNT-1:0] thread_running;
   record_pkg::plane_status_t plane_status;
   logic rec_valid;
   record_pkg::rec_byte_t rec_out;
   logic rec_ready;
   logic stall;
   logic [15:0] seed;
   logic [31:0] rv;
   int fails;
   int compares;

   axis_status_record_packer i_dut (.clk(clk), .srst(srst), .ce(ce), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .axis_in(axis_in),
      .thread_running(thread_running), .plane_status(plane_status), .rec_valid(rec_valid),
      .rec_out(rec_out), .rec_ready(rec_ready));

   host_reader i_host (.clk(clk), .srst(srst), .stall(stall), .rec_valid(rec_valid),
      .rec_out(rec_out), .rec_ready(rec_ready));

   // Free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Byte due at a record offset; fields go out low byte first, spare bits zero
   function automatic logic [7:0] exp_byte(input int off);
      record_pkg::axis_in_t a;
      logic [287:0] blk;
      a = axis_in[(off - 190) / 36];
      blk = {a.user_status_variable, 8'h00, a.hall, a.analog, a.torque, a.velocity,
         a.aux_pos, a.pos_err, a.motor_pos, a.ref_pos, a.stop_code, a.switches[7:6], 2'b00,
         a.switches[3:0], a.status};
      return blk[((off - 190) % 36) * 8 +: 8];
   endfunction

   // Plane word uses only bits 15, 5, 4 and 3
   function automatic logic [31:0] plane_word(input logic [3:0] p);
      return {16'h0, p[3], 9'h0, p[2], p[1], p[0], 3'h0};
   endfunction

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask

   task automatic fill_inputs();
      logic [record_pkg::NUM_AXES*$bits(record_pkg::axis_in_t)-1:0] flat;
      // Eight bits a step: the axis input width is not a multiple of sixteen
      for (int i = 0; i < $bits(flat) / 8; i++) begin
         seed = lfsr_next(seed);
         flat[i*8 +: 8] = seed[7:0];
      end
      @(posedge clk);
      axis_in <= flat;
   endtask

   task automatic wait_bytes(input int n);
      int k;
      k = 0;
      while (i_host.count < n && k < 5000) begin
         @(posedge clk);
         k++;
      end
      if (i_host.count < n) begin
         fails++;
         print_verdict();
      end
   endtask

   task automatic wait_idle();
      int k;
      k = 0;
      rv = 32'h1;
      while (rv[0] !== 1'b0 && k < 50) begin
         bus_rd(record_pkg::REG_STATUS, rv);
         k++;
      end
      if (rv[0] !== 1'b0) begin
         fails++;
         print_verdict();
      end
   endtask

   task automatic check_record();
      for (int off = 190; off <= 369; off++) begin
         chk8(i_host.mem[off], exp_byte(off));
         chk8({7'h0, i_host.last_seen[off]}, {7'h0, off == 369});
      end
      chk32(i_host.order_errs, 32'h0);
   endtask

   task automatic print_verdict();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Main sequence: registers, a stalled record, then an auto-started corner record
   initial begin
      srst = 1'b1;
      ce = 1'b1;
      addr = '0;
      wr_data = '0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      stall = 1'b1;
      axis_in = '0;
      thread_running = '0;
      plane_status = '0;
      seed = 16'hf1a6;
      fails = 0;
      compares = 0;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      bus_rd(record_pkg::REG_CTRL, rv);
      chk32(rv, 32'h0);
      bus_rd(record_pkg::REG_STATUS, rv);
      chk32(rv, 32'h0);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr_next(seed);
         @(posedge clk);
         thread_running <= seed[7:0];
         plane_status <= seed[11:8];
         bus_rd(record_pkg::REG_THREAD, rv);
         chk32(rv, {24'h0, seed[7:0]});
         bus_rd(record_pkg::REG_PLANE, rv);
         chk32(rv, plane_word(seed[11:8]));
      end
      // Unmapped place reads zero and ignores writes
      bus_wr(4'h2, 32'hffffffff);
      bus_rd(4'h2, rv);
      chk32(rv, 32'h0);
      // Host stalled: second start while busy is dropped, buffer fills
      fill_inputs();
      repeat (4) @(posedge clk);
      bus_wr(record_pkg::REG_CTRL, 32'h2);
      // Clock enable low: the pending start must wait, nothing may reach the host
      ce <= 1'b0;
      repeat (20) @(posedge clk);
      chk8({7'h0, rec_valid}, 8'h00);
      ce <= 1'b1;
      bus_wr(record_pkg::REG_CTRL, 32'h2);
      bus_rd(record_pkg::REG_CTRL, rv);
      chk32(rv, 32'h0);
      repeat (40) @(posedge clk);
      bus_rd(record_pkg::REG_STATUS, rv);
      chk32(rv, 32'h3);
      stall <= 1'b0;
      wait_bytes(180);
      wait_idle();
      bus_rd(record_pkg::REG_STATUS, rv);
      chk32(rv, 32'h100);
      check_record();
      // Corner: every bit of the first axis set, spare bits must still read zero
      fill_inputs();
      @(posedge clk);
      axis_in[0] <= '1;
      repeat (4) @(posedge clk);
      bus_wr(record_pkg::REG_CTRL, 32'h1);
      bus_rd(record_pkg::REG_CTRL, rv);
      chk32(rv, 32'h1);
      bus_wr(record_pkg::REG_CTRL, 32'h0);
      wait_bytes(360);
      wait_idle();
      bus_rd(record_pkg::REG_STATUS, rv);
      chk32(rv, 32'h200);
      check_record();
      print_verdict();
   end
endmodule

`default_nettype wire
